// File: core/timer_pkg.sv
// Operation
// R1: Mode 0 counts up forever, never clears on match, wraps 0xFFFF to 0x0000.
// R2: Normal mode raises wrap flag as count becomes zero; counter only sets it.
// R3: Normal mode accepts a count write at any time.
// R4: Clear-on-match mode clears count at compare A (mode 4) or capture top (mode 12).
// R5: Clear-on-match top writes act at once; a top below count wraps via 0xFFFF.
// R6: Clear-on-match top hit sets compare A flag or capture flag, per top source.
// R7: Clear-on-match with action 1 toggles channel A output at every match.
// R8: Latch reaches pin only when direction is output and routing enabled.
// R9: Clear-on-match sets wrap flag when count rolls from max to 0x0000.
// R10: Fast PWM modes 5,6,7,14,15 top at 0xFF,0x1FF,0x3FF,capture,compare A; then clear.
// R11: Fast PWM action 2 sets on match, clears at top; action 3 the reverse.
// R12: Fast PWM sets wrap flag at top, plus top-source flag in same cycle.
// R13: Fixed top masks compare bits above resolution on every compare write.
// R14: Fast PWM capture top is unbuffered; a top below count wraps via 0xFFFF.
// R15: Fast PWM compare A writes go to buffer, loaded at top with clear and wrap.
// R16: Software keeps variable top at least 0x0003, at most full 16 bits.
// R17: Software keeps new top at or above every compare value.
// R18: Fast PWM compare 0 gives one-cycle spike; compare equal top gives constant level.
// R19: Fast PWM channel A action 1 toggles on match, compare stays buffered.
// R20: Counting depends only on mode select, never on output actions.
// R21: Timer tick is clock divided by 1, 8, 64, 256 or 1024.
// R22: Non-PWM action sets, clears or toggles latch at match; routing gates pin.
// R23: A count write suppresses every compare match in the next timer tick.
// R24: Match sets its flag one tick later; cleared by service or write of one.
package timer_pkg;
  localparam int CNT_W = 16;
  localparam int CH_N = 2;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00ff;
  localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01ff;
  localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03ff;
  // Waveform mode codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_MATCH_A = 4'h4;
  localparam logic [3:0] MODE_PWM_8 = 4'h5;
  localparam logic [3:0] MODE_PWM_9 = 4'h6;
  localparam logic [3:0] MODE_PWM_10 = 4'h7;
  localparam logic [3:0] MODE_MATCH_CAP = 4'hc;
  localparam logic [3:0] MODE_PWM_CAP = 4'he;
  localparam logic [3:0] MODE_PWM_A = 4'hf;
  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_TWO = 2'h2;
  localparam logic [1:0] ACT_THREE = 2'h3;
  localparam logic LATCH_RESET = 1'b0;
  // Prescaler select codes and divider widths
  localparam int PRESCALE_W = 10;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam int DIV8_BITS = 3;
  localparam int DIV64_BITS = 6;
  localparam int DIV256_BITS = 8;
  localparam int DIV1024_BITS = 10;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 10'h000;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 10'h001;
endpackage

// File: core/timer_prescaler.sv
`timescale 1ns/100ps
module timer_prescaler #(
  parameter int PRESCALE_W = timer_pkg::PRESCALE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Division select
  input wire logic [2:0] clock_select,
  // Timer tick
  output logic timer_tick
);
  logic [PRESCALE_W-1:0] div_q;
  logic [PRESCALE_W-1:0] div_d;

  // Free running; a select change may give one short first period
  always_comb begin
    div_d = div_q + timer_pkg::PRESCALE_ONE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= timer_pkg::PRESCALE_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  always_comb begin
    unique case (clock_select)
      timer_pkg::CS_DIV1: timer_tick = 1'b1; // [R21]
      timer_pkg::CS_DIV8: timer_tick = &div_q[timer_pkg::DIV8_BITS-1:0]; // [R21]
      timer_pkg::CS_DIV64: timer_tick = &div_q[timer_pkg::DIV64_BITS-1:0]; // [R21]
      timer_pkg::CS_DIV256: timer_tick = &div_q[timer_pkg::DIV256_BITS-1:0]; // [R21]
      timer_pkg::CS_DIV1024: timer_tick = &div_q[timer_pkg::DIV1024_BITS-1:0]; // [R21]
      default: timer_tick = 1'b0;
    endcase
  end
endmodule

// File: core/wide_timer_wave_modes.sv
`timescale 1ns/100ps
module wide_timer_wave_modes (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode and clock control
  input wire logic [3:0] waveform_mode_select,
  input wire logic [2:0] clock_select,
  input wire logic [1:0] output_action_select_a,
  input wire logic [1:0] output_action_select_b,
  // Software writes
  input wire logic count_write,
  input wire logic [timer_pkg::CNT_W-1:0] count_wdata,
  input wire logic compare_a_write,
  input wire logic [timer_pkg::CNT_W-1:0] compare_a_wdata,
  input wire logic compare_b_write,
  input wire logic [timer_pkg::CNT_W-1:0] compare_b_wdata,
  input wire logic capture_top_write,
  input wire logic [timer_pkg::CNT_W-1:0] capture_top_wdata,
  input wire logic force_match_strobe_a,
  input wire logic force_match_strobe_b,
  // Flag clears, from service or write of one
  input wire logic wrap_flag_clear,
  input wire logic compare_a_flag_clear,
  input wire logic compare_b_flag_clear,
  input wire logic capture_flag_clear,
  // Pin control
  input wire logic pin_route_enable_a,
  input wire logic pin_route_enable_b,
  input wire logic pin_direction_bit_a,
  input wire logic pin_direction_bit_b,
  input wire logic port_value_a,
  input wire logic port_value_b,
  // Register views
  output logic [timer_pkg::CNT_W-1:0] count_value,
  output logic [timer_pkg::CNT_W-1:0] compare_a_value,
  output logic [timer_pkg::CNT_W-1:0] compare_b_value,
  output logic [timer_pkg::CNT_W-1:0] compare_a_buffer,
  output logic [timer_pkg::CNT_W-1:0] compare_b_buffer,
  output logic [timer_pkg::CNT_W-1:0] capture_top_value,
  // Flags
  output logic wrap_flag,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic capture_flag,
  // Waveform
  output logic wave_out_latch_a,
  output logic wave_out_latch_b,
  output logic wave_out_a,
  output logic wave_out_a_oe,
  output logic wave_out_b,
  output logic wave_out_b_oe
);
  localparam int W = timer_pkg::CNT_W;
  localparam int N = timer_pkg::CH_N;

  logic tick;
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic block_q;
  logic block_d;
  logic [W-1:0] capture_q;
  logic [W-1:0] capture_d;
  logic wrap_q;
  logic wrap_d;
  logic cap_flag_q;
  logic cap_flag_d;
  logic is_pwm;
  logic is_match_clr;
  logic fixed_top;
  logic [W-1:0] top_value;
  logic [W-1:0] wr_mask;
  logic at_top;
  logic top_event;
  logic [W-1:0] active_q [N];
  logic [W-1:0] buffer_q [N];
  logic match [N];
  logic flag_q [N];
  logic latch_q [N];
  logic cmp_write [N];
  logic [W-1:0] cmp_wdata [N];
  logic force_strobe [N];
  logic flag_clear [N];
  logic [1:0] action [N];
  logic route_en [N];
  logic dir_out [N];
  logic port_val [N];
  logic pin_val [N];

  timer_prescaler #(
    .PRESCALE_W(timer_pkg::PRESCALE_W)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .clock_select(clock_select),
    .timer_tick(tick)
  );

  // Channel fan-in
  assign cmp_write[0] = compare_a_write;
  assign cmp_write[1] = compare_b_write;
  assign cmp_wdata[0] = compare_a_wdata;
  assign cmp_wdata[1] = compare_b_wdata;
  assign force_strobe[0] = force_match_strobe_a;
  assign force_strobe[1] = force_match_strobe_b;
  assign flag_clear[0] = compare_a_flag_clear;
  assign flag_clear[1] = compare_b_flag_clear;
  assign action[0] = output_action_select_a;
  assign action[1] = output_action_select_b;
  assign route_en[0] = pin_route_enable_a;
  assign route_en[1] = pin_route_enable_b;
  assign dir_out[0] = pin_direction_bit_a;
  assign dir_out[1] = pin_direction_bit_b;
  assign port_val[0] = port_value_a;
  assign port_val[1] = port_value_b;

  // Mode decode; only the mode select shapes counting [R20]
  always_comb begin
    is_pwm = 1'b0;
    is_match_clr = 1'b0;
    fixed_top = 1'b0;
    top_value = timer_pkg::COUNT_MAX;
    wr_mask = timer_pkg::COUNT_MAX;
    unique case (waveform_mode_select)
      timer_pkg::MODE_MATCH_A: begin
        is_match_clr = 1'b1;
        top_value = active_q[0]; // [R4]
      end
      timer_pkg::MODE_MATCH_CAP: begin
        is_match_clr = 1'b1;
        top_value = capture_q; // [R4]
      end
      timer_pkg::MODE_PWM_8: begin
        is_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = timer_pkg::TOP_8BIT; // [R10]
        wr_mask = timer_pkg::TOP_8BIT; // [R13]
      end
      timer_pkg::MODE_PWM_9: begin
        is_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = timer_pkg::TOP_9BIT; // [R10]
        wr_mask = timer_pkg::TOP_9BIT; // [R13]
      end
      timer_pkg::MODE_PWM_10: begin
        is_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = timer_pkg::TOP_10BIT; // [R10]
        wr_mask = timer_pkg::TOP_10BIT; // [R13]
      end
      timer_pkg::MODE_PWM_CAP: begin
        is_pwm = 1'b1;
        top_value = capture_q; // [R10] [R14]
      end
      timer_pkg::MODE_PWM_A: begin
        is_pwm = 1'b1;
        top_value = active_q[0]; // [R10]
      end
      default: begin
        // Normal and the dual-slope codes count as mode 0 here
        top_value = timer_pkg::COUNT_MAX; // [R1]
      end
    endcase
  end

  // Exact equality only: a top written below the count is missed [R5] [R14]
  // A register-defined top is a compare match, so a count write blocks it too
  assign at_top = (is_pwm | is_match_clr) & (count_q == top_value) & (fixed_top | ~block_q); // [R23]
  assign top_event = tick & at_top;

  // Counter, match blocking, capture top and top-driven flags
  always_comb begin
    count_d = count_q;
    block_d = block_q;
    capture_d = capture_q;
    wrap_d = wrap_q;
    cap_flag_d = cap_flag_q;
    if (count_write) begin
      count_d = count_wdata; // [R3]
      block_d = 1'b1; // [R23]
    end else if (tick) begin
      block_d = 1'b0; // [R23]
      if (at_top) begin
        count_d = timer_pkg::COUNT_ZERO; // [R4] [R10]
      end else begin
        count_d = count_q + 16'h0001; // [R1] [R5] [R14]
      end
    end
    if (capture_top_write) begin
      capture_d = capture_top_wdata; // [R5] [R14]
    end
    if (wrap_flag_clear) begin
      wrap_d = 1'b0;
    end
    // A count write in the same cycle means no rollover, so no wrap
    if (tick & ~count_write & ~is_pwm & (count_q == timer_pkg::COUNT_MAX)) begin
      wrap_d = 1'b1; // [R2] [R9]
    end
    if (top_event & is_pwm) begin
      wrap_d = 1'b1; // [R12]
    end
    if (capture_flag_clear) begin
      cap_flag_d = 1'b0; // [R24]
    end
    if (top_event & (waveform_mode_select == timer_pkg::MODE_MATCH_CAP ||
        waveform_mode_select == timer_pkg::MODE_PWM_CAP)) begin
      cap_flag_d = 1'b1; // [R6] [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= timer_pkg::COUNT_ZERO;
      block_q <= 1'b0;
      capture_q <= timer_pkg::COUNT_ZERO;
      wrap_q <= 1'b0;
      cap_flag_q <= 1'b0;
    end else begin
      count_q <= count_d;
      block_q <= block_d;
      capture_q <= capture_d;
      wrap_q <= wrap_d;
      cap_flag_q <= cap_flag_d;
    end
  end

  // Compare channels
  for (genvar ch = 0; ch < N; ch++) begin : g_ch
    logic [W-1:0] act_d;
    logic [W-1:0] buf_d;
    logic flag_d;
    logic latch_d;
    logic hit;

    assign match[ch] = (count_q == active_q[ch]) & ~block_q; // [R23]
    assign hit = tick & match[ch];

    always_comb begin
      act_d = active_q[ch];
      buf_d = buffer_q[ch];
      flag_d = flag_q[ch];
      latch_d = latch_q[ch];
      // Buffer loads at top, together with counter clear and wrap [R15]
      if (top_event & is_pwm) begin
        act_d = buffer_q[ch]; // [R15]
      end
      if (cmp_write[ch]) begin
        buf_d = cmp_wdata[ch] & wr_mask; // [R13] [R15]
        if (~is_pwm) begin
          act_d = cmp_wdata[ch] & wr_mask; // [R5] [R13]
        end
      end
      if (flag_clear[ch]) begin
        flag_d = 1'b0; // [R24]
      end
      if (hit) begin
        flag_d = 1'b1; // [R6] [R24]
      end
      if (is_pwm) begin
        // At compare equal top both events coincide; top wins, level stays constant
        unique case (action[ch])
          timer_pkg::ACT_TOGGLE: begin
            if (hit && ch == 0) begin
              latch_d = ~latch_q[ch]; // [R19]
            end
          end
          timer_pkg::ACT_TWO: begin
            if (hit) begin
              latch_d = 1'b1; // [R11] [R18]
            end
            if (top_event) begin
              latch_d = 1'b0; // [R11] [R18]
            end
          end
          timer_pkg::ACT_THREE: begin
            if (hit) begin
              latch_d = 1'b0; // [R11] [R18]
            end
            if (top_event) begin
              latch_d = 1'b1; // [R11] [R18]
            end
          end
          timer_pkg::ACT_NONE: begin
            latch_d = latch_q[ch];
          end
        endcase
      end else if (hit | force_strobe[ch]) begin
        // Force acts like a match but leaves flags and counter alone
        unique case (action[ch])
          timer_pkg::ACT_TOGGLE: latch_d = ~latch_q[ch]; // [R7] [R22]
          timer_pkg::ACT_TWO: latch_d = 1'b0; // [R22]
          timer_pkg::ACT_THREE: latch_d = 1'b1; // [R22]
          timer_pkg::ACT_NONE: latch_d = latch_q[ch];
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        active_q[ch] <= timer_pkg::COUNT_ZERO;
        buffer_q[ch] <= timer_pkg::COUNT_ZERO;
        flag_q[ch] <= 1'b0;
        latch_q[ch] <= timer_pkg::LATCH_RESET;
      end else begin
        active_q[ch] <= act_d;
        buffer_q[ch] <= buf_d;
        flag_q[ch] <= flag_d;
        latch_q[ch] <= latch_d;
      end
    end

    // Port function keeps the pin unless routed and an action is chosen
    assign pin_val[ch] = (route_en[ch] && action[ch] != timer_pkg::ACT_NONE) ?
                         latch_q[ch] : port_val[ch]; // [R8] [R22]
  end

  // Outputs
  assign count_value = count_q;
  assign compare_a_value = active_q[0];
  assign compare_b_value = active_q[1];
  assign compare_a_buffer = buffer_q[0];
  assign compare_b_buffer = buffer_q[1];
  assign capture_top_value = capture_q;
  assign wrap_flag = wrap_q;
  assign compare_a_flag = flag_q[0];
  assign compare_b_flag = flag_q[1];
  assign capture_flag = cap_flag_q;
  assign wave_out_latch_a = latch_q[0];
  assign wave_out_latch_b = latch_q[1];
  assign wave_out_a = pin_val[0];
  assign wave_out_b = pin_val[1];
  assign wave_out_a_oe = pin_direction_bit_a; // [R8]
  assign wave_out_b_oe = pin_direction_bit_b; // [R8]
endmodule

// File: sim/timer_properties.sv
`timescale 1ns/100ps
module timer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs watched
  input wire logic [3:0] waveform_mode_select,
  input wire logic [2:0] clock_select,
  input wire logic [1:0] output_action_select_a,
  input wire logic count_write,
  input wire logic [15:0] count_wdata,
  input wire logic compare_a_write,
  input wire logic force_match_strobe_a,
  input wire logic wrap_flag_clear,
  input wire logic pin_route_enable_a,
  input wire logic pin_direction_bit_a,
  input wire logic port_value_a,
  // Outputs watched
  input wire logic [15:0] count_value,
  input wire logic [15:0] compare_a_value,
  input wire logic [15:0] compare_a_buffer,
  input wire logic wrap_flag,
  input wire logic compare_a_flag,
  input wire logic wave_out_latch_a,
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe
);
  logic t, m0, m4, m5, m15, hit;
  // Tick is internal, so tick-dependent checks judge only divide-by-one cycles
  assign t = clock_select == timer_pkg::CS_DIV1 && !count_write;
  assign m0 = t && waveform_mode_select == timer_pkg::MODE_NORMAL;
  assign m4 = t && waveform_mode_select == timer_pkg::MODE_MATCH_A;
  assign m5 = t && waveform_mode_select == timer_pkg::MODE_PWM_8;
  assign m15 = t && waveform_mode_select == timer_pkg::MODE_PWM_A;
  assign hit = count_value == compare_a_value;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_normal_step: assert property (m0 |=>
    count_value == $past(count_value) + 16'h0001) else $error("normal step wrong");
  a_normal_wrap: assert property (m0 && count_value == 16'hffff |=>
    count_value == 16'h0000 && wrap_flag) else $error("normal wrap wrong");
  a_count_load: assert property (count_write |=>
    count_value == $past(count_wdata)) else $error("count load wrong");
  a_match_clear: assert property (m4 && hit && !$past(count_write) |=>
    count_value == 16'h0000 && compare_a_flag) else $error("match clear wrong");
  a_match_toggle: assert property (m4 && hit && !$past(count_write)
    && !force_match_strobe_a && output_action_select_a == timer_pkg::ACT_TOGGLE
    |=> wave_out_latch_a != $past(wave_out_latch_a)) else $error("toggle wrong");
  a_pin_gate: assert property (
    wave_out_a_oe == pin_direction_bit_a && wave_out_a == (pin_route_enable_a
    && output_action_select_a != 2'h0 ? wave_out_latch_a : port_value_a))
    else $error("pin gating wrong");
  a_fixed_top: assert property (m5 && count_value == timer_pkg::TOP_8BIT |=>
    count_value == 16'h0000 && wrap_flag) else $error("fixed top wrong");
  a_pwm_set: assert property (m5 && hit && !$past(count_write)
    && count_value != timer_pkg::TOP_8BIT && output_action_select_a == timer_pkg::ACT_TWO
    |=> wave_out_latch_a) else $error("pwm set wrong");
  a_buffer_load: assert property (m15 && hit && !$past(count_write) |=>
    compare_a_value == $past(compare_a_buffer) && count_value == 16'h0000
    && wrap_flag && compare_a_flag) else $error("buffer load wrong");
  a_fixed_mask: assert property (
    waveform_mode_select == timer_pkg::MODE_PWM_8 && compare_a_write
    |=> compare_a_buffer[15:8] == 8'h00) else $error("mask wrong");
  a_flag_sticky: assert property (wrap_flag && !wrap_flag_clear |=> wrap_flag)
    else $error("wrap flag lost");
  c_match_clear: cover property (m4 && hit);
  c_buffer: cover property (m15 && hit);
  c_wrap: cover property ($rose(wrap_flag));
endmodule

bind wide_timer_wave_modes timer_checker i_timer_checker (
  .clk, .rst, .waveform_mode_select, .clock_select, .output_action_select_a,
  .count_write, .count_wdata, .compare_a_write, .force_match_strobe_a,
  .wrap_flag_clear, .pin_route_enable_a, .pin_direction_bit_a, .port_value_a,
  .count_value, .compare_a_value, .compare_a_buffer, .wrap_flag,
  .compare_a_flag, .wave_out_latch_a, .wave_out_a, .wave_out_a_oe
);

// File: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk, rst, count_write, compare_a_write, compare_b_write, capture_top_write;
  logic [3:0] waveform_mode_select;
  logic [2:0] clock_select;
  logic [1:0] output_action_select_a, output_action_select_b;
  logic [15:0] count_wdata, compare_a_wdata, compare_b_wdata, capture_top_wdata;
  logic force_match_strobe_a, wrap_flag_clear, compare_a_flag_clear, capture_flag_clear;
  logic pin_route_enable_a, pin_direction_bit_a, port_value_a, l;
  logic [15:0] count_value, compare_a_value, compare_a_buffer, compare_b_buffer, c;
  logic wrap_flag, compare_a_flag, capture_flag, wave_out_latch_a, wave_out_a, wave_out_a_oe;
  logic [15:0] compare_b_value, capture_top_value;
  logic compare_b_flag, wave_out_latch_b, wave_out_b, wave_out_b_oe;
  int num_errors, comparisons, cycles;
  int sh[4] = '{3, 6, 8, 10};

  wide_timer_wave_modes i_wide_timer_wave_modes (
    .clk, .rst, .waveform_mode_select, .clock_select, .output_action_select_a,
    .output_action_select_b, .count_write, .count_wdata, .compare_a_write,
    .compare_a_wdata, .compare_b_write, .compare_b_wdata, .capture_top_write,
    .capture_top_wdata, .force_match_strobe_a,
    .force_match_strobe_b(force_match_strobe_a), .wrap_flag_clear, .compare_a_flag_clear,
    .compare_b_flag_clear(compare_a_flag_clear), .capture_flag_clear, .pin_route_enable_a,
    .pin_route_enable_b(pin_route_enable_a), .pin_direction_bit_a,
    .pin_direction_bit_b(pin_direction_bit_a), .port_value_a, .port_value_b(port_value_a),
    .count_value, .compare_a_value, .compare_b_value, .compare_a_buffer, .compare_b_buffer,
    .capture_top_value, .wrap_flag, .compare_a_flag, .compare_b_flag, .capture_flag,
    .wave_out_latch_a, .wave_out_latch_b, .wave_out_a, .wave_out_a_oe, .wave_out_b,
    .wave_out_b_oe
  );

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about 3500 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic chk1(input logic s, input logic e);
    check({15'h0, s}, {15'h0, e});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sel 0 count, 1 compare A, 2 compare B, 3 capture top
  task automatic wr(input int k, input logic [15:0] v);
    @(posedge clk);
    {count_wdata, compare_a_wdata, compare_b_wdata, capture_top_wdata} <= {4{v}};
    {count_write, compare_a_write, compare_b_write, capture_top_write} <= 4'h8 >> k;
    @(posedge clk);
    {count_write, compare_a_write, compare_b_write, capture_top_write} <= 4'h0;
    #1;
  endtask

  task automatic setm(input logic [3:0] m, input logic [1:0] a);
    @(posedge clk);
    waveform_mode_select <= m;
    output_action_select_a <= a;
    output_action_select_b <= a;
    #1;
  endtask

  task automatic clr();
    @(posedge clk);
    {wrap_flag_clear, compare_a_flag_clear, capture_flag_clear} <= 3'h7;
    @(posedge clk);
    {wrap_flag_clear, compare_a_flag_clear, capture_flag_clear} <= 3'h0;
    #1;
  endtask

  task automatic frc(input logic [1:0] a);
    @(posedge clk);
    {output_action_select_a, output_action_select_b} <= {2{a}};
    force_match_strobe_a <= 1'h1;
    @(posedge clk);
    force_match_strobe_a <= 1'h0;
    #1;
  endtask

  task automatic pin(input logic [2:0] v);
    @(posedge clk);
    {pin_route_enable_a, pin_direction_bit_a, port_value_a} <= v;
    #1;
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    for (int i = 0; i < 2000 && count_value !== v; i++) step(1);
    check(count_value, v);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    clock_select = timer_pkg::CS_DIV1;
    waveform_mode_select = timer_pkg::MODE_NORMAL;
    {output_action_select_a, output_action_select_b} = 4'h0;
    {count_write, compare_a_write, compare_b_write, capture_top_write} = 4'h0;
    {count_wdata, compare_a_wdata, compare_b_wdata, capture_top_wdata} = 64'h0;
    {force_match_strobe_a, wrap_flag_clear, compare_a_flag_clear} = 3'h0;
    {capture_flag_clear, pin_route_enable_a, pin_direction_bit_a, port_value_a} = 4'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    #1;
    wr(0, 16'hfffe);
    check(count_value, 16'hfffe);
    step(2);
    check(count_value, 16'h0000);
    chk1(wrap_flag, 1'h1);
    step(3);
    chk1(wrap_flag, 1'h1);
    clr();
    chk1(wrap_flag, 1'h0);
    done("normal");
    pin(3'h6);
    for (int i = 0; i < 3; i++) begin
      frc(2'(3 - i));
      check({14'h0, wave_out_latch_a, wave_out_latch_b}, {14'h0, {2{~1'(i)}}});
    end
    check({12'h0, wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe}, 16'h000f);
    pin(3'h0);
    check({12'h0, wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe}, 16'h0000);
    pin(3'h6);
    done("force");
    // Park the count far above the top first
    setm(timer_pkg::MODE_MATCH_A, timer_pkg::ACT_TOGGLE);
    wr(0, 16'h0080);
    wr(1, 16'h0010);
    check(compare_a_value, 16'h0010);
    clr();
    wr(0, 16'h0010);
    step(1);
    check(count_value, 16'h0011);
    chk1(compare_a_flag, 1'h0);
    l = wave_out_latch_a;
    wr(0, 16'h000e);
    step(3);
    check(count_value, 16'h0000);
    chk1(compare_a_flag, 1'h1);
    chk1(wave_out_latch_a, ~l);
    wr(1, 16'h0005);
    wr(0, 16'hfffe);
    step(2);
    chk1(wrap_flag, 1'h1);
    step(6);
    check(count_value, 16'h0000);
    wr(3, 16'h0007);
    check(capture_top_value, 16'h0007);
    setm(timer_pkg::MODE_MATCH_CAP, timer_pkg::ACT_NONE);
    wr(0, 16'h0000);
    clr();
    step(5);
    chk1(capture_flag, 1'h0);
    step(1);
    check(count_value, 16'h0000);
    chk1(capture_flag, 1'h1);
    done("match clear");
    // Tops stay at least 3 and at or above compare A; compare B stays above the variable tops
    setm(timer_pkg::MODE_PWM_8, timer_pkg::ACT_TWO);
    wr(1, 16'h1234);
    check(compare_a_buffer, 16'h0034);
    wr(2, 16'habcd);
    check(compare_b_buffer, 16'h00cd);
    wr(0, 16'h00fd);
    step(2);
    check(compare_a_value, 16'h0005);
    step(1);
    check(compare_a_value, 16'h0034);
    check(compare_b_value, 16'h00cd);
    chk1(wrap_flag, 1'h1);
    chk1(wave_out_latch_a, 1'h0);
    wait_cnt(16'h0034);
    step(1);
    chk1(wave_out_a, 1'h1);
    wait_cnt(16'h00ff);
    step(1);
    chk1(wave_out_a, 1'h0);
    setm(timer_pkg::MODE_PWM_8, timer_pkg::ACT_THREE);
    wait_cnt(16'h00ff);
    step(1);
    chk1(wave_out_latch_a, 1'h1);
    wait_cnt(16'h0034);
    step(1);
    chk1(wave_out_latch_a, 1'h0);
    for (int i = 0; i < 3; i++) begin
      setm(4'(5 + i), timer_pkg::ACT_NONE);
      clr();
      wr(0, (16'h0100 << i) - 16'h0001);
      step(1);
      check(count_value, 16'h0000);
      chk1(wrap_flag, 1'h1);
    end
    setm(timer_pkg::MODE_PWM_A, timer_pkg::ACT_TOGGLE);
    wr(1, 16'h0020);
    check(compare_a_value, 16'h0034);
    clr();
    wait_cnt(16'h0034);
    step(1);
    check(compare_a_value, 16'h0020);
    check({13'h0, wrap_flag, compare_a_flag, compare_b_flag}, 16'h0006);
    l = wave_out_latch_a;
    wait_cnt(16'h0020);
    step(1);
    chk1(wave_out_latch_a, ~l);
    wr(3, 16'h0040);
    setm(timer_pkg::MODE_PWM_CAP, timer_pkg::ACT_NONE);
    wr(0, 16'h0041);
    step(1);
    check(count_value, 16'h0042);
    clr();
    wr(0, 16'h003e);
    step(3);
    check(count_value, 16'h0000);
    check({14'h0, wrap_flag, capture_flag}, 16'h0003);
    done("pwm");
    setm(timer_pkg::MODE_NORMAL, timer_pkg::ACT_NONE);
    for (int i = 2; i < 7; i++) begin
      @(posedge clk);
      clock_select <= (i < 6) ? 3'(i) : timer_pkg::CS_STOP;
      step(1);
      c = count_value;
      step(i < 6 ? 2 << sh[i - 2] : 20);
      check(count_value, c + (i < 6 ? 16'h0002 : 16'h0000));
    end
    done("prescale");
    wrap_up();
  end
endmodule
